// *** scrs_pkg.sv ***
// shared constants for the secondary clock run switch
package scrs_pkg;

    // apb register map, byte addresses
    localparam logic [7:0] OSC_CONTROL_OFF       = 8'h00;
    localparam logic [7:0] TIMER_ONE_CONTROL_OFF = 8'h04;
    localparam logic [7:0] OSC_TUNING_OFF        = 8'h08;
    localparam logic [7:0] SWITCH_STATUS_OFF     = 8'h0c;

    // osc_control fields
    localparam int CLOCK_SELECT_LSB   = 0;  // two-bit clock_select_field
    localparam int PRI_READY_BIT      = 3;  // primary_clock_ready_flag, ro
    localparam int IDLE_ENABLE_BIT    = 7;  // idle_on_sleep_enable
    // timer_one_control fields
    localparam int SEC_OSC_ENABLE_BIT = 3;  // secondary_osc_enable
    localparam int SEC_ACTIVE_BIT     = 6;  // secondary_clock_active_flag, ro

    // clock_select_field code that requests secondary run
    localparam logic [1:0] SELECT_SECONDARY = 2'h1;
    localparam logic [1:0] SELECT_RESET     = 2'h0;

    // system clock source steering code
    localparam logic [1:0] SRC_NONE      = 2'h0;
    localparam logic [1:0] SRC_PRIMARY   = 2'h1;
    localparam logic [1:0] SRC_SECONDARY = 2'h2;

    // tuning: signed trim, centre of the fast oscillator frequency code
    localparam int         TUNE_WIDTH      = 5;
    localparam logic [4:0] TUNE_RESET      = 5'h00;
    localparam logic [7:0] FAST_FREQ_CENTRE = 8'h80;
    localparam logic [7:0] SLOW_FREQ_CODE   = 8'h80;

    // one-hot switch sequencer states
    typedef enum logic [5:0] {
        ST_PRIMARY_RUN_MODE   = 6'h01,  // running on the primary clock
        ST_SEC_WAIT  = 6'h02,  // clocks held until secondary osc runs
        ST_SEC_BREAK = 6'h04,  // gap before making the secondary clock
        ST_SECONDARY_RUN_MODE   = 6'h08,  // running on the secondary clock
        ST_PRI_START = 6'h10,  // primary starting, secondary still clocks
        ST_PRI_BREAK = 6'h20   // gap before making the primary clock
    } scrs_state_type;

endpackage

// *** scrs_osc_tune.sv ***
`timescale 1ns/1ps
`default_nettype none
// internal oscillator trim register and frequency codes
module scrs_osc_tune #(
    parameter int WIDTH = scrs_pkg::TUNE_WIDTH
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             tune_wr,
    input  wire logic [WIDTH-1:0] tune_wdata,
    output logic      [WIDTH-1:0] tune_q,
    output logic      [7:0]       fast_freq_q,
    output logic      [7:0]       slow_freq_q
);
    import scrs_pkg::*;

    logic [WIDTH-1:0] tune_d;       // next trim value
    logic [7:0]       fast_freq_d;  // centre plus signed trim

    // only the fast oscillator trim moves; the slow rc has no input here
    assign tune_d      = tune_wr ? tune_wdata : tune_q;
    // signed trim, so a larger value always means a higher frequency
    assign fast_freq_d = FAST_FREQ_CENTRE
                       + 8'(signed'(tune_d));

    // trim storage and derived codes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tune_q      <= WIDTH'(TUNE_RESET);
            fast_freq_q <= FAST_FREQ_CENTRE;
            slow_freq_q <= SLOW_FREQ_CODE;
        end else begin
            tune_q      <= tune_d;
            fast_freq_q <= fast_freq_d;
            slow_freq_q <= SLOW_FREQ_CODE;
        end
    end

    chk_tune_direction: assert property (
        @(posedge pclk) disable iff (!presetn)
        tune_wr && (signed'(tune_wdata) > signed'(tune_q))
        |=> fast_freq_q > $past(fast_freq_q))
        else $error("raising the trim did not raise the frequency");

    chk_slow_untouched: assert property (
        @(posedge pclk) disable iff (!presetn)
        tune_wr |=> slow_freq_q == SLOW_FREQ_CODE)
        else $error("trim write disturbed the slow rc code");

endmodule
`default_nettype wire

// *** scrs_clock_switch.sv ***
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - writing select 01 enters secondary run
// - entry stops primary, sets active, clears ready
// - secondary osc disabled: select stored, clock kept
// - enabled but not running: hold clocks
// - return: secondary clocks while primary starts
// - primary ready: switch back, update both flags
// - return keeps idle, select; secondary keeps running
// - tuning changes fast osc only, not slow
// - larger tuning value means higher frequency
module scrs_clock_switch (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic        pri_osc_ready,   // primary osc stable
    input  wire logic        sec_osc_running, // secondary osc oscillating
    output logic             pready,
    output logic      [31:0] prdata,
    output logic             pslverr,
    output logic             pri_osc_enable,
    output logic             sec_osc_enable,
    output logic      [1:0]  sys_clk_src,
    output logic             sys_clk_hold,
    output logic      [4:0]  fast_osc_trim,
    output logic      [7:0]  fast_osc_freq,
    output logic      [7:0]  slow_osc_freq
);
    import scrs_pkg::*;

    // address hit test, shared by the read and write decoders
    function automatic logic addr_hit(input logic [7:0] a,
                                      input logic [7:0] off);
        addr_hit = (a == off);
    endfunction

    // system clock source for each sequencer state
    function automatic logic [1:0] src_of(input scrs_state_type s);
        case (s)
            ST_PRIMARY_RUN_MODE:   src_of = SRC_PRIMARY;
            ST_SECONDARY_RUN_MODE,
            ST_PRI_START: src_of = SRC_SECONDARY;
            default:      src_of = SRC_NONE;  // waits and break gaps
        endcase
    endfunction

    scrs_state_type state_q, state_d;      // switch sequencer
    logic [1:0]  select_q,  select_d;      // clock_select_field
    logic        idle_q,    idle_d;        // idle_on_sleep_enable
    logic        sec_en_q,  sec_en_d;      // secondary_osc_enable
    logic        sec_act_q, sec_act_d;     // secondary_clock_active_flag
    logic        pri_rdy_q, pri_rdy_d;     // primary_clock_ready_flag
    logic        pri_en_d;                 // primary osc enable next
    logic [1:0]  src_d;                    // clock source next
    logic [31:0] rdata_d;                  // read mux
    logic        setup, access, wr_en;     // apb phases
    logic        hit_ctl, hit_t1, hit_tune, hit_stat, hit_any;
    logic        wr_ctl, wr_t1, wr_tune;   // register write strobes
    logic        req_sec, req_pri;         // sequencer triggers
    logic [1:0]  wr_select;                // select value being written

    // apb phases; the slave is zero wait, so each access takes one cycle
    assign setup    = psel && !penable;
    assign access   = psel && penable && pready;
    assign wr_en    = access && pwrite;
    assign hit_ctl  = addr_hit(paddr, OSC_CONTROL_OFF);
    assign hit_t1   = addr_hit(paddr, TIMER_ONE_CONTROL_OFF);
    assign hit_tune = addr_hit(paddr, OSC_TUNING_OFF);
    assign hit_stat = addr_hit(paddr, SWITCH_STATUS_OFF);
    assign hit_any  = hit_ctl || hit_t1 || hit_tune || hit_stat;
    assign wr_ctl   = wr_en && hit_ctl;
    assign wr_t1    = wr_en && hit_t1;
    assign wr_tune  = wr_en && hit_tune;
    assign wr_select = pwdata[CLOCK_SELECT_LSB +: 2];

    // software-held fields; hardware never rewrites them on a return
    assign select_d = wr_ctl ? wr_select : select_q;
    assign idle_d   = wr_ctl ? pwdata[IDLE_ENABLE_BIT] : idle_q;
    assign sec_en_d = wr_t1 ? pwdata[SEC_OSC_ENABLE_BIT] : sec_en_q;

    // entry is judged at the write itself; a later enable does not enter
    assign req_sec = wr_ctl && (wr_select == SELECT_SECONDARY)
                  && sec_en_q;
    assign req_pri = wr_ctl && (wr_select != SELECT_SECONDARY);

    // sequencer next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_PRIMARY_RUN_MODE: begin
                // disabled secondary osc: write stored, clock unchanged
                if (req_sec) begin
                    state_d = sec_osc_running ? ST_SEC_BREAK
                                              : ST_SEC_WAIT;
                end
            end
            ST_SEC_WAIT: begin
                // clocks are already stopped, so the jump to secondary run needs no extra gap; an abort still passes ST_PRI_BREAK
                if (!sec_en_q || req_pri) begin
                    state_d = ST_PRI_BREAK;
                end else if (sec_osc_running) begin
                    state_d = ST_SECONDARY_RUN_MODE;
                end
            end
            ST_SEC_BREAK: state_d = ST_SECONDARY_RUN_MODE;
            ST_SECONDARY_RUN_MODE: begin
                if (req_pri) begin
                    state_d = ST_PRI_START;
                end
            end
            ST_PRI_START: begin
                // secondary keeps clocking until the primary is stable
                if (pri_osc_ready) begin
                    state_d = ST_PRI_BREAK;
                end
            end
            ST_PRI_BREAK: state_d = ST_PRIMARY_RUN_MODE;
            default: state_d = ST_PRIMARY_RUN_MODE;
        endcase
    end

    // outputs follow the next state so they line up with state_q
    assign src_d     = src_of(state_d);
    assign pri_en_d  = (state_d != ST_SECONDARY_RUN_MODE);
    assign sec_act_d = (state_d == ST_SECONDARY_RUN_MODE)
                    || (state_d == ST_PRI_START)
                    // an aborted wait never ran on the secondary clock
                    || (state_d == ST_PRI_BREAK && sec_act_q);
    // ready drops on secondary entry and comes back when the return ends
    assign pri_rdy_d = (state_q == ST_PRI_BREAK && state_d == ST_PRIMARY_RUN_MODE)
                    || ((state_d == ST_PRIMARY_RUN_MODE || state_d == ST_SEC_WAIT
                         || state_d == ST_SEC_BREAK)
                        && (pri_rdy_q || pri_osc_ready));

    // read data, captured in the setup phase; unmapped reads as zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit_ctl) begin
            rdata_d[CLOCK_SELECT_LSB +: 2] = select_q;
            rdata_d[PRI_READY_BIT]         = pri_rdy_q;
            rdata_d[IDLE_ENABLE_BIT]       = idle_q;
        end else if (hit_t1) begin
            rdata_d[SEC_OSC_ENABLE_BIT]    = sec_en_q;
            rdata_d[SEC_ACTIVE_BIT]        = sec_act_q;
        end else if (hit_tune) begin
            rdata_d[TUNE_WIDTH-1:0]        = fast_osc_trim;
        end else if (hit_stat) begin
            rdata_d[5:0]                   = state_q;
        end
    end

    // bus answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= 1'b1;  // zero wait after the first cycle
            if (setup) begin
                prdata  <= rdata_d;
                pslverr <= !hit_any;
            end
        end
    end

    // control fields and flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            select_q  <= SELECT_RESET;
            idle_q    <= 1'b0;
            sec_en_q  <= 1'b0;
            sec_act_q <= 1'b0;
            pri_rdy_q <= 1'b0;
        end else begin
            select_q  <= select_d;
            idle_q    <= idle_d;
            sec_en_q  <= sec_en_d;
            sec_act_q <= sec_act_d;
            pri_rdy_q <= pri_rdy_d;
        end
    end

    // sequencer and clock steering outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q        <= ST_PRIMARY_RUN_MODE;
            sys_clk_src    <= SRC_PRIMARY;
            sys_clk_hold   <= 1'b0;
            pri_osc_enable <= 1'b1;
            sec_osc_enable <= 1'b0;
        end else begin
            state_q        <= state_d;
            sys_clk_src    <= src_d;
            sys_clk_hold   <= (state_d == ST_SEC_WAIT);
            pri_osc_enable <= pri_en_d;
            sec_osc_enable <= sec_en_d;  // never dropped by a return
        end
    end

    // internal oscillator trim
    scrs_osc_tune #(
        .WIDTH (TUNE_WIDTH)
    ) u_tune (
        .pclk        (pclk),
        .presetn     (presetn),
        .tune_wr     (wr_tune),
        .tune_wdata  (pwdata[TUNE_WIDTH-1:0]),
        .tune_q      (fast_osc_trim),
        .fast_freq_q (fast_osc_freq),
        .slow_freq_q (slow_osc_freq)
    );

    // named steps of the two switch sequences
    sequence seq_make_secondary;
        state_q == ST_SEC_BREAK && sys_clk_src == SRC_NONE
        ##1 state_q == ST_SECONDARY_RUN_MODE && sys_clk_src == SRC_SECONDARY;
    endsequence

    sequence seq_make_primary;
        state_q == ST_PRI_BREAK && sys_clk_src == SRC_NONE
        ##1 state_q == ST_PRIMARY_RUN_MODE && sys_clk_src == SRC_PRIMARY
            && !sec_act_q && pri_rdy_q;
    endsequence

    chk_secondary_entry: assert property (
        @(posedge pclk) disable iff (!presetn)
        state_q == ST_PRIMARY_RUN_MODE && req_sec && sec_osc_running
        |=> seq_make_secondary)
        else $error("secondary entry sequence wrong");

    chk_entry_flags: assert property (
        @(posedge pclk) disable iff (!presetn)
        state_q == ST_SECONDARY_RUN_MODE |-> !pri_osc_enable && sec_act_q
        && !pri_rdy_q)
        else $error("secondary run flags wrong");

    chk_disabled_guard: assert property (
        @(posedge pclk) disable iff (!presetn)
        state_q == ST_PRIMARY_RUN_MODE && wr_ctl && wr_select == SELECT_SECONDARY
        && !sec_en_q |=> state_q == ST_PRIMARY_RUN_MODE
        && sys_clk_src == SRC_PRIMARY)
        else $error("entry taken with secondary osc disabled");

    chk_hold_clocks: assert property (
        @(posedge pclk) disable iff (!presetn)
        state_q == ST_SEC_WAIT |-> sys_clk_hold
        && sys_clk_src == SRC_NONE)
        else $error("clocks not held while secondary starts");

    chk_primary_start: assert property (
        @(posedge pclk) disable iff (!presetn)
        state_q == ST_SECONDARY_RUN_MODE && req_pri |=> state_q == ST_PRI_START
        && pri_osc_enable && sys_clk_src == SRC_SECONDARY)
        else $error("return did not keep secondary clocking");

    chk_return_done: assert property (
        @(posedge pclk) disable iff (!presetn)
        state_q == ST_PRI_START && pri_osc_ready
        |=> seq_make_primary)
        else $error("return to primary sequence wrong");

    chk_fields_kept: assert property (
        @(posedge pclk) disable iff (!presetn)
        state_q == ST_PRI_BREAK && !wr_ctl && !wr_t1
        |=> $stable(select_q) && $stable(idle_q) && sec_osc_enable
            == $past(sec_osc_enable))
        else $error("return changed software fields");

    chk_break_first: assert property (
        @(posedge pclk) disable iff (!presetn)
        $changed(sys_clk_src) && $past(sys_clk_src) != SRC_NONE
        |-> sys_clk_src == SRC_NONE)
        else $error("clock source switched without a gap");

endmodule
`default_nettype wire

// *** secondary_clock_run_switch_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// one mismatch check, counted and reported on the spot
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
    error_cnt++; $display("[ERR] %0t got %h exp %h", $time, got, exp); \
    end end
module secondary_clock_run_switch_tb_top;
    import scrs_pkg::*;
    logic        pclk;             // 10 mhz bus clock
    logic        presetn;          // async reset, active low
    logic        psel;             // apb select
    logic        penable;          // apb access phase
    logic        pwrite;           // apb direction
    logic [7:0]  paddr;            // apb byte address
    logic [31:0] pwdata;           // apb write data
    logic        pri_osc_ready;    // primary oscillator stable
    logic        sec_osc_running;  // secondary oscillator oscillating
    logic        pready;           // apb ready
    logic [31:0] prdata;           // apb read data
    logic        pslverr;          // apb error
    logic        pri_osc_enable;   // primary oscillator on
    logic        sec_osc_enable;   // secondary oscillator on
    logic [1:0]  sys_clk_src;      // steering code of the system clock
    logic        sys_clk_hold;     // clocks held off
    logic [4:0]  fast_osc_trim;    // trim value
    logic [7:0]  fast_osc_freq;    // fast oscillator frequency code
    logic [7:0]  slow_osc_freq;    // slow rc frequency code
    int          error_cnt;        // mismatches
    int          n_compared;       // comparisons made
    logic [31:0] rd;               // last read word
    logic        err;              // last pslverr
    logic        gap;              // a no-source cycle was seen
    logic [7:0]  ef;               // expected fast frequency code
    logic [4:0]  tv [4] = '{5'h01, 5'h1f, 5'h0f, 5'h10}; // trim boundaries

    scrs_clock_switch dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pri_osc_ready(pri_osc_ready), .sec_osc_running(sec_osc_running),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .pri_osc_enable(pri_osc_enable), .sec_osc_enable(sec_osc_enable),
        .sys_clk_src(sys_clk_src), .sys_clk_hold(sys_clk_hold),
        .fast_osc_trim(fast_osc_trim), .fast_osc_freq(fast_osc_freq),
        .slow_osc_freq(slow_osc_freq));

    // free-running bus clock
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // one apb transfer; the master never assumes a wait-state count
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // sampled before this edge's updates land, as the slave sees it
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 50) begin
            error_cnt++;
            $display("[ERR] %0t no pready", $time);
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // let n edges pass, then look once the updates have settled
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // wait for a clock source, noting whether a gap came first
    task automatic wait_src(input logic [1:0] want);
        int n;
        gap = 1'b0;
        for (n = 0; n < 20 && sys_clk_src !== want; n++) begin
            settle(1);
            if (sys_clk_src === SRC_NONE) gap = 1'b1;
        end
        `CHK(sys_clk_src, want)
    endtask

    // verdict, reached from the end of the tests or from the watchdog
    task automatic wrap_up;
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // hang guard: the tests need about a hundred cycles
    initial begin
        #(5000 * 100);
        error_cnt++;
        wrap_up;
    end

    initial begin
        error_cnt = 0;
        n_compared = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pri_osc_ready = 1'b0;
        sec_osc_running = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // reset state: primary run, slow clock fixed
        settle(1);
        `CHK({pri_osc_enable, sys_clk_src}, {1'b1, SRC_PRIMARY})
        `CHK(slow_osc_freq, SLOW_FREQ_CODE)
        // inputs move only at a rising edge
        @(posedge pclk);
        pri_osc_ready <= 1'b1;
        apb(1'b0, SWITCH_STATUS_OFF, 32'h0);
        `CHK(rd, {26'h0, ST_PRIMARY_RUN_MODE})
        // unmapped place is refused
        apb(1'b0, 8'h10, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        // secondary oscillator disabled: request ignored
        apb(1'b1, OSC_CONTROL_OFF, 32'h1);
        settle(3);
        `CHK(sys_clk_src, SRC_PRIMARY)
        apb(1'b0, SWITCH_STATUS_OFF, 32'h0);
        `CHK(rd, {26'h0, ST_PRIMARY_RUN_MODE})
        apb(1'b1, OSC_CONTROL_OFF, 32'h0);
        // enabled but not running: clocks must be held
        apb(1'b1, TIMER_ONE_CONTROL_OFF, 32'h8);
        // the write lands at this edge; look once it has settled
        settle(0);
        `CHK(sec_osc_enable, 1'b1)
        apb(1'b1, OSC_CONTROL_OFF, 32'h81);
        settle(3);
        `CHK({sys_clk_hold, sys_clk_src}, {1'b1, SRC_NONE})
        apb(1'b0, SWITCH_STATUS_OFF, 32'h0);
        `CHK(rd, {26'h0, ST_SEC_WAIT})
        sec_osc_running <= 1'b1;
        wait_src(SRC_SECONDARY);
        `CHK({sys_clk_hold, pri_osc_enable}, 2'b00)
        // primary shut down, so it is no longer ready
        @(posedge pclk);
        pri_osc_ready <= 1'b0;
        apb(1'b0, TIMER_ONE_CONTROL_OFF, 32'h0);
        `CHK(rd, 32'h48)
        apb(1'b0, OSC_CONTROL_OFF, 32'h0);
        `CHK(rd, 32'h81)
        // return: secondary keeps clocking while primary starts
        apb(1'b1, OSC_CONTROL_OFF, 32'h80);
        settle(4);
        `CHK({pri_osc_enable, sys_clk_src}, {1'b1, SRC_SECONDARY})
        apb(1'b0, SWITCH_STATUS_OFF, 32'h0);
        `CHK(rd, {26'h0, ST_PRI_START})
        apb(1'b0, TIMER_ONE_CONTROL_OFF, 32'h0);
        `CHK(rd, 32'h48)
        pri_osc_ready <= 1'b1;
        wait_src(SRC_PRIMARY);
        `CHK(gap, 1'b1)
        apb(1'b0, OSC_CONTROL_OFF, 32'h0);
        `CHK(rd, 32'h88)
        apb(1'b0, TIMER_ONE_CONTROL_OFF, 32'h0);
        `CHK(rd, 32'h08)
        `CHK(sec_osc_enable, 1'b1)
        // osc already running before the request: one gap, then secondary
        apb(1'b1, OSC_CONTROL_OFF, 32'h1);
        settle(0);
        `CHK({sys_clk_src, sys_clk_hold}, {SRC_NONE, 1'b0})
        settle(1);
        `CHK({sys_clk_src, pri_osc_enable}, {SRC_SECONDARY, 1'b0})
        // trim boundaries; high word bits must not stick
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OSC_TUNING_OFF, 32'hffffffe0 | {27'h0, tv[i]});
            ef = FAST_FREQ_CENTRE + {{3{tv[i][4]}}, tv[i]};
            settle(1);
            `CHK(fast_osc_freq, ef)
            `CHK(slow_osc_freq, SLOW_FREQ_CODE)
            `CHK(fast_osc_trim, tv[i])
            apb(1'b0, OSC_TUNING_OFF, 32'h0);
            `CHK(rd, {27'h0, tv[i]})
        end
        // mid-run reset out of secondary run: back to primary, trim cleared
        @(posedge pclk);
        presetn <= 1'b0;
        settle(2);
        `CHK({pready, sec_osc_enable, fast_osc_trim}, 7'h00)
        `CHK(sys_clk_src, SRC_PRIMARY)
        `CHK(fast_osc_freq, FAST_FREQ_CENTRE)
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OSC_TUNING_OFF, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, SWITCH_STATUS_OFF, 32'h0);
        `CHK(rd, {26'h0, ST_PRIMARY_RUN_MODE})
        wrap_up;
    end
endmodule
`undef CHK
`default_nettype wire
